// file: hw/isp_spi_slave.sv
`timescale 1ns/1ps
module isp_spi_slave (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire logic I_CS_N,
    input wire logic I_SCLK,
    input wire logic I_DIN,
    input wire logic [7:0] I_SAMPLE_PERIOD_SETTING,
    input wire logic [15:0] I_RD_DATA,
    output logic O_DOUT,
    output logic O_DOUT_OE,
    output logic [5:0] O_RD_ADDR,
    output isp_pkg::isp_req_s O_REQ,
    output logic O_REQ_VALID,
    output logic O_TIMING_ERR
);
    logic [2:0] pins_sync;
    logic cs_n_s;
    logic sclk_s;
    logic din_s;
    logic cs_n_d_reg;
    logic sclk_d_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic [isp_pkg::FRAME_BITS-1:0] rx_reg;
    logic [isp_pkg::FRAME_BITS-1:0] tx_reg;
    logic [isp_pkg::CNT_W-1:0] bit_cnt_reg;
    logic [isp_pkg::TMR_W-1:0] gap_cnt_reg;
    logic [isp_pkg::TMR_W-1:0] rate_cnt_reg;
    logic fast_mode;
    logic [isp_pkg::TMR_W-1:0] gap_min;
    logic [isp_pkg::TMR_W-1:0] rate_min;

    isp_sync #(.WIDTH(3)) u_sync (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_async({I_CS_N, I_SCLK, I_DIN}),
        .o_sync(pins_sync)
    );
    assign cs_n_s = pins_sync[2];
    assign sclk_s = pins_sync[1];
    assign din_s = pins_sync[0];

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            cs_n_d_reg <= 1'b1;
            sclk_d_reg <= 1'b1;
        end else begin
            cs_n_d_reg <= cs_n_s;
            sclk_d_reg <= sclk_s;
        end
    end

    // edges only count inside a frame
    assign sclk_rise = !cs_n_s && !sclk_d_reg && sclk_s;
    assign sclk_fall = !cs_n_s && sclk_d_reg && !sclk_s;
    assign cs_fall = cs_n_d_reg && !cs_n_s;
    assign cs_rise = !cs_n_d_reg && cs_n_s;

    assign fast_mode = I_SAMPLE_PERIOD_SETTING <= isp_pkg::FAST_MAX_SETTING;
    assign gap_min = fast_mode ? isp_pkg::TMR_W'(isp_pkg::FAST_GAP_CYC)
                               : isp_pkg::TMR_W'(isp_pkg::NORM_GAP_CYC);
    assign rate_min = fast_mode ? isp_pkg::TMR_W'(isp_pkg::FAST_RATE_CYC)
                                : isp_pkg::TMR_W'(isp_pkg::NORM_RATE_CYC);

    // receive shift and bit count
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            rx_reg <= '0;
            bit_cnt_reg <= '0;
        end else if (cs_fall) begin
            bit_cnt_reg <= '0;
        end else if (sclk_rise) begin
            rx_reg <= {rx_reg[isp_pkg::FRAME_BITS-2:0], din_s};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
    end

    // transmit: read data presented at select fall, msb first
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            tx_reg <= isp_pkg::TX_RESET;
        end else if (cs_fall) begin
            tx_reg <= {I_RD_DATA[isp_pkg::FRAME_BITS-2:0], 1'b0};
        end else if (sclk_fall && bit_cnt_reg != '0) begin
            // first fall keeps the msb up until the first rise samples it
            tx_reg <= {tx_reg[isp_pkg::FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_DOUT <= 1'b0;
            O_DOUT_OE <= 1'b0;
        end else if (cs_fall) begin
            O_DOUT <= I_RD_DATA[isp_pkg::FRAME_BITS-1];
            O_DOUT_OE <= 1'b1;
        end else if (cs_n_s) begin
            O_DOUT_OE <= 1'b0;
        end else if (sclk_fall && bit_cnt_reg != '0) begin
            O_DOUT <= tx_reg[isp_pkg::FRAME_BITS-1];
        end
    end

    // decode a complete 16-clock frame at select rise
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_REQ <= '0;
            O_REQ_VALID <= 1'b0;
            O_RD_ADDR <= '0;
        end else begin
            O_REQ_VALID <= 1'b0;
            if (cs_rise && bit_cnt_reg == isp_pkg::CNT_W'(isp_pkg::FRAME_BITS)
                && !rx_reg[isp_pkg::CMD_RSV_POS]) begin
                O_REQ.wr <= rx_reg[isp_pkg::CMD_WR_POS];
                O_REQ.addr <= rx_reg[isp_pkg::ADDR_MSB:isp_pkg::ADDR_LSB];
                O_REQ.data <= rx_reg[isp_pkg::DATA_BITS-1:0];
                O_REQ_VALID <= 1'b1;
                if (!rx_reg[isp_pkg::CMD_WR_POS]) begin
                    // read address steers next frame's data
                    O_RD_ADDR <= rx_reg[isp_pkg::ADDR_MSB:isp_pkg::ADDR_LSB];
                end
            end
        end
    end

    // watch master spacing; flag is sticky until reset
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            gap_cnt_reg <= '1;
            rate_cnt_reg <= '1;
            O_TIMING_ERR <= 1'b0;
        end else begin
            if (cs_rise) begin
                gap_cnt_reg <= '0;
            end else if (gap_cnt_reg != '1) begin
                gap_cnt_reg <= gap_cnt_reg + 1'b1;
            end
            if (cs_fall) begin
                rate_cnt_reg <= '0;
            end else if (rate_cnt_reg != '1) begin
                rate_cnt_reg <= rate_cnt_reg + 1'b1;
            end
            if (cs_fall && (gap_cnt_reg < gap_min || rate_cnt_reg < rate_min))
            begin
                O_TIMING_ERR <= 1'b1;
            end
            if (cs_rise && bit_cnt_reg != isp_pkg::CNT_W'(isp_pkg::FRAME_BITS))
            begin
                O_TIMING_ERR <= 1'b1;
            end
        end
    end

    chk_dout_release: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        cs_n_s |=> !O_DOUT_OE)
        else $error("dout driven with select high");

    chk_msb_first: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        cs_fall |=> O_DOUT_OE && O_DOUT == $past(I_RD_DATA[15]))
        else $error("msb not presented at select fall");

    chk_dout_stable: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (!cs_n_s && !sclk_fall && !cs_fall) |=> $stable(O_DOUT))
        else $error("dout changed without falling clock");

    chk_rx_sample: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        sclk_rise && !cs_fall |=> rx_reg[0] == $past(din_s))
        else $error("input bit not sampled on rise");

    chk_idle_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        cs_n_s && cs_n_d_reg |=> $stable(rx_reg) && $stable(bit_cnt_reg))
        else $error("state moved while deselected");

    chk_req_frame: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_REQ_VALID |-> $past(bit_cnt_reg) == 5'h10 && $past(cs_rise))
        else $error("request without full frame");

    chk_write_fields: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_REQ_VALID && O_REQ.wr |-> O_REQ.data == $past(rx_reg[7:0]))
        else $error("write data mismatch");

    chk_read_addr: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_REQ_VALID && !O_REQ.wr |-> O_RD_ADDR == O_REQ.addr)
        else $error("read address not latched");

    chk_gap_flag: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        cs_fall && gap_cnt_reg < gap_min |=> O_TIMING_ERR)
        else $error("short stall not flagged");
endmodule : isp_spi_slave

// file: shared/isp_pkg.sv
// Function
// - clock idles high, data sampled on rising edges
// - first output bit appears on select fall, before any clock edge
// - later output bits change after each falling clock edge but the first
// - each input bit is sampled on the rising clock edge
// - output released to high impedance while select is high
// - a frame is 16 clocks, 16 bits each way at once
// - write frame: 1, 0, 6-bit byte address, 8 data bits
// - read frame: 0, 0, address; next frame returns 16-bit register
// - with select high, clock and input activity are ignored
package isp_pkg;
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 6;
    localparam int DATA_BITS = 8;
    localparam int CNT_W = 5;
    localparam int CMD_WR_POS = 15;
    localparam int CMD_RSV_POS = 14;
    localparam int ADDR_MSB = 13;
    localparam int ADDR_LSB = 8;
    localparam logic [7:0] FAST_MAX_SETTING = 8'h09;
    localparam logic [15:0] TX_RESET = 16'h0000;
    localparam int CLK_HZ = 10_000_000;
    localparam int FAST_GAP_US = 9;
    localparam int NORM_GAP_US = 75;
    localparam int FAST_RATE_US = 40;
    localparam int NORM_RATE_US = 160;
    // least times round up to whole cycles
    localparam int FAST_GAP_CYC = (FAST_GAP_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int NORM_GAP_CYC = (NORM_GAP_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int FAST_RATE_CYC = (FAST_RATE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int NORM_RATE_CYC = (NORM_RATE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int TMR_W = 12;

    typedef struct packed {
        logic wr;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } isp_req_s;
endpackage : isp_pkg

// file: hw/isp_sync.sv
`timescale 1ns/1ps
module isp_sync #(
    parameter int WIDTH = 3
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // reset to idle-high pins: select high, clock high
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_reg <= '1;
            o_sync <= '1;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : isp_sync

// file: bench/isp_master.sv
`timescale 1ns/1ps
module isp_master (
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    input wire logic i_dout
);
    int half_ns = 400;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_din = 1'b0;
    end
    task automatic frame(input logic [15:0] tx, input int nbits,
                         input int gap_ns, output logic [15:0] rx);
        rx = 16'h0000;
        o_cs_n = 1'b0;
        #(half_ns);
        for (int i = 0; i < nbits; i++) begin
            o_sclk = 1'b0;
            o_din = tx[15-i];
            #(half_ns);
            rx = {rx[14:0], i_dout};
            o_sclk = 1'b1;
            #(half_ns);
        end
        o_cs_n = 1'b1;
        // the input flips after select rises, which the slave must ignore
        o_din = ~o_din;
        #(gap_ns);
    endtask : frame
    task automatic wiggle();
        repeat (8) begin
            o_sclk = ~o_sclk;
            o_din = ~o_din;
            #(half_ns);
        end
    endtask : wiggle
endmodule : isp_master

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] setting = 8'h09;
    logic [15:0] rd_data = 16'h0000;
    logic cs_n, sclk, din, dout, oe, req_valid, err;
    logic [5:0] rd_addr;
    isp_pkg::isp_req_s req, last_req;
    logic [15:0] rx;
    int failures = 0;
    int compares = 0;
    int nreq = 0;
    wire dout_pin = oe ? dout : ~dout;
    always #50 clk = ~clk;
    isp_spi_slave u_isp_spi_slave (.I_CLK_SYS(clk), .I_RSTN(rstn),
        .I_CS_N(cs_n), .I_SCLK(sclk), .I_DIN(din),
        .I_SAMPLE_PERIOD_SETTING(setting), .I_RD_DATA(rd_data),
        .O_DOUT(dout), .O_DOUT_OE(oe), .O_RD_ADDR(rd_addr), .O_REQ(req),
        .O_REQ_VALID(req_valid), .O_TIMING_ERR(err));
    isp_master u_isp_master (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
        .i_dout(dout_pin));
    always @(posedge clk) begin
        rd_data <= {rd_addr, 4'hC, rd_addr};
        if (req_valid === 1'b1) begin
            nreq <= nreq + 1;
            last_req <= req;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    function automatic logic [15:0] flat(isp_pkg::isp_req_s r);
        return {r.wr, 1'b0, r.addr, r.data};
    endfunction : flat
    task automatic test_write_read();
        u_isp_master.frame(16'hAAC3, 16, 30000, rx);
        check(rx, 16'h0300);
        check(flat(last_req), 16'hAAC3);
        u_isp_master.frame(16'h15FF, 16, 30000, rx);
        check({10'h000, rd_addr}, 16'h0015);
        check(flat(last_req), 16'h15FF);
        u_isp_master.frame(16'h8001, 16, 30000, rx);
        check(rx, 16'h5715);
        check(flat(last_req), 16'h8001);
        $display("test write and read done");
    endtask : test_write_read
    task automatic test_idle();
        int n0;
        n0 = nreq;
        u_isp_master.wiggle();
        repeat (20) @(posedge clk);
        check({15'h0000, oe}, 16'h0000);
        check(nreq[15:0], n0[15:0]);
        $display("test idle done");
    endtask : test_idle
    task automatic test_normal();
        #200000;
        @(posedge clk) setting <= 8'h0A;
        #23;
        u_isp_master.half_ns = 2000;
        u_isp_master.frame(16'h8155, 16, 130000, rx);
        check(flat(last_req), 16'h8155);
        check({15'h0000, err}, 16'h0000);
        $display("test normal mode done");
    endtask : test_normal
    task automatic test_short();
        int n0;
        n0 = nreq;
        u_isp_master.frame(16'hAAC3, 15, 150000, rx);
        check(nreq[15:0], n0[15:0]);
        check({15'h0000, err}, 16'h0001);
        $display("test short frame done");
    endtask : test_short
    task automatic test_spacing();
        @(posedge clk) rstn <= 1'b0;
        setting <= 8'h09;
        u_isp_master.half_ns = 400;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #23;
        u_isp_master.frame(16'h8001, 16, 2000, rx);
        check({15'h0000, err}, 16'h0000);
        u_isp_master.frame(16'h8001, 16, 30000, rx);
        check({15'h0000, err}, 16'h0001);
        $display("test spacing done");
    endtask : test_spacing
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #23;
        test_write_read();
        test_idle();
        test_normal();
        test_short();
        test_spacing();
        conclude();
    end
endmodule : testbench
